// ### logic/gpio_port.sv
// top of the gpio port: pin direction/data, interrupt sources, six channels
// assumes PIN_IN is asynchronous and software uses the plain strobe port
`timescale 1ns/10ps
module gpio_port (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [31:0] PIN_IN,
  output logic [31:0] PIN_OUT,
  output logic [31:0] PIN_OE,
  output logic [5:0] PIN_IRQ,
  output logic IRQ
);
  gpio_pkg::bus_req_t req;

  // pin synchroniser state
  logic [31:0] sync1;
  logic [31:0] sync2;
  logic [31:0] sync3;
  logic [31:0] pin;
  logic [31:0] next_pin;

  // port state
  logic [31:0] dir;
  logic [31:0] data;
  logic [31:0] next_dir;
  logic [31:0] next_data;

  // interrupt source state
  gpio_pkg::pin_cfg_t cfg;
  gpio_pkg::pin_cfg_t next_cfg;
  logic [31:0] swreq;
  logic [31:0] next_swreq;
  logic [31:0] prev_act;
  logic [31:0] src;
  logic [31:0] act;
  logic [31:0] ev;

  // block status and read port
  logic [5:0] stat;
  logic [5:0] imask;
  logic [5:0] next_stat;
  logic [5:0] next_imask;
  logic next_irq;
  logic [31:0] next_rdata;
  logic [31:0] word;
  logic [31:0] ch_rd [gpio_pkg::NCH];
  logic [5:0] ch_irq;

  always_comb begin
    req.addr = ADDR;
    req.wdata = WDATA;
    req.wr = WR;
    req.rd = RD;
  end

  // three-stage synchroniser, a change is taken once stages two and three agree
  always_comb begin
    next_pin = pin;
    for (int i = 0; i < gpio_pkg::NPINS; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_pin[i] = sync3[i];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= gpio_pkg::ZERO_WORD;
      sync2 <= gpio_pkg::ZERO_WORD;
      sync3 <= gpio_pkg::ZERO_WORD;
      pin <= gpio_pkg::ZERO_WORD;
    end else begin
      sync1 <= PIN_IN;
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= next_pin;
    end
  end

  // direction and output data, touched only by port addresses
  always_comb begin
    next_dir = gpio_pkg::w1m(dir, WDATA, WR && ADDR == gpio_pkg::DIR_ADDR,
                             WR && ADDR == gpio_pkg::DIR_SET_ADDR,
                             WR && ADDR == gpio_pkg::DIR_CLR_ADDR, 1'b0);
    next_data = gpio_pkg::w1m(data, WDATA, WR && ADDR == gpio_pkg::DATA_ADDR,
                              WR && ADDR == gpio_pkg::DATA_SET_ADDR,
                              WR && ADDR == gpio_pkg::DATA_CLR_ADDR,
                              WR && ADDR == gpio_pkg::DATA_TGL_ADDR);
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      dir <= gpio_pkg::ZERO_WORD;
      data <= gpio_pkg::ZERO_WORD;
    end else begin
      dir <= next_dir;
      data <= next_data;
    end
  end

  always_comb begin
    PIN_OUT = data;
    PIN_OE = dir;
  end

  // interrupt source selection, polarity and edge detection
  always_comb begin
    next_cfg = cfg;
    if (WR && ADDR == gpio_pkg::SENSE_ADDR) begin
      next_cfg.edge_mode = WDATA;
    end
    if (WR && ADDR == gpio_pkg::BOTH_ADDR) begin
      next_cfg.both = WDATA;
    end
    if (WR && ADDR == gpio_pkg::INVERT_ADDR) begin
      next_cfg.invert = WDATA;
    end
    next_swreq = gpio_pkg::w1m(swreq, WDATA, WR && ADDR == gpio_pkg::SWREQ_ADDR,
                               WR && ADDR == gpio_pkg::SWREQ_SET_ADDR,
                               WR && ADDR == gpio_pkg::SWREQ_CLR_ADDR, 1'b0);
    // inputs use the pin, outputs only the software request
    src = (~dir & pin) | (dir & swreq);
    act = src ^ cfg.invert;
    // both-edge mode also counts the inactive-going edge
    ev = cfg.edge_mode & ((act & ~prev_act) | (cfg.both & ~act & prev_act));
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg <= '0;
      swreq <= gpio_pkg::ZERO_WORD;
      prev_act <= gpio_pkg::ZERO_WORD;
    end else begin
      cfg <= next_cfg;
      swreq <= next_swreq;
      prev_act <= act;
    end
  end

  // the six channels
  generate
    for (genvar c = 0; c < gpio_pkg::NCH; c++) begin : g_ch
      pin_irq_channel #(
        .BASE(8'(gpio_pkg::CH_BASE + c * gpio_pkg::CH_STRIDE))
      ) u_ch (
        .clk(MCLK),
        .rst_n(RESETN),
        .req(req),
        .pin_raw(pin),
        .pin_level(act),
        .pin_event(ev),
        .edge_mode(cfg.edge_mode),
        .rd_word(ch_rd[c]),
        .irq(ch_irq[c])
      );
    end
  endgenerate

  always_comb begin
    PIN_IRQ = ch_irq;
  end

  // block status: channel requests stick until written with one, set wins
  always_comb begin
    next_stat = stat;
    if (WR && ADDR == gpio_pkg::IRQ_STAT_ADDR) begin
      next_stat = stat & ~WDATA[5:0];
    end
    next_stat = next_stat | ch_irq;
    next_imask = (WR && ADDR == gpio_pkg::IRQ_MASK_ADDR) ? WDATA[5:0] : imask;
    next_irq = |(stat & imask);
  end

  // read mux, one cycle latency, zero outside a read
  always_comb begin
    word = gpio_pkg::ZERO_WORD;
    unique case (ADDR)
      gpio_pkg::DIR_ADDR: word = dir;
      gpio_pkg::DATA_ADDR: word = data;
      gpio_pkg::PIN_ADDR: word = pin;
      gpio_pkg::SENSE_ADDR: word = cfg.edge_mode;
      gpio_pkg::BOTH_ADDR: word = cfg.both;
      gpio_pkg::INVERT_ADDR: word = cfg.invert;
      gpio_pkg::SWREQ_ADDR: word = swreq;
      gpio_pkg::IRQ_STAT_ADDR: word = {26'h000_0000, stat};
      gpio_pkg::IRQ_MASK_ADDR: word = {26'h000_0000, imask};
      default: begin
        for (int c = 0; c < gpio_pkg::NCH; c++) begin
          word = word | ch_rd[c];
        end
      end
    endcase
    next_rdata = RD ? word : gpio_pkg::ZERO_WORD;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      stat <= gpio_pkg::CH_ZERO;
      imask <= gpio_pkg::CH_ZERO;
      IRQ <= 1'b0;
      RDATA <= gpio_pkg::ZERO_WORD;
    end else begin
      stat <= next_stat;
      imask <= next_imask;
      IRQ <= next_irq;
      RDATA <= next_rdata;
    end
  end
endmodule

// ### logic/gpio_pkg.sv
// constants, carrier types and shared decode for the gpio port with pin interrupts
// assumes one 10 mhz clock (MCLK) and a plain address/strobe register port
package gpio_pkg;
  localparam int NPINS = 32;
  localparam int HALF = 8;
  localparam int NHALF = 4;
  localparam int NCH = 6;
  localparam int AW = 8;
  localparam int DW = 32;

  // port registers
  localparam logic [7:0] DIR_ADDR = 8'h00;
  localparam logic [7:0] DIR_SET_ADDR = 8'h04;
  localparam logic [7:0] DIR_CLR_ADDR = 8'h08;
  localparam logic [7:0] DATA_ADDR = 8'h0C;
  localparam logic [7:0] DATA_SET_ADDR = 8'h10;
  localparam logic [7:0] DATA_CLR_ADDR = 8'h14;
  localparam logic [7:0] DATA_TGL_ADDR = 8'h18;
  localparam logic [7:0] PIN_ADDR = 8'h1C;
  // interrupt source configuration, block status and mask
  localparam logic [7:0] SENSE_ADDR = 8'h20;
  localparam logic [7:0] BOTH_ADDR = 8'h24;
  localparam logic [7:0] INVERT_ADDR = 8'h28;
  localparam logic [7:0] SWREQ_ADDR = 8'h2C;
  localparam logic [7:0] SWREQ_SET_ADDR = 8'h30;
  localparam logic [7:0] SWREQ_CLR_ADDR = 8'h34;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h38;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h3C;

  // channel windows: base + index * stride, offsets below
  localparam logic [7:0] CH_BASE = 8'h40;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam int CH_SHIFT = 5;
  localparam logic [4:0] CH_ASSIGN_OFF = 5'h00;
  localparam logic [4:0] CH_MASK_OFF = 5'h04;
  localparam logic [4:0] CH_MASK_SET_OFF = 5'h08;
  localparam logic [4:0] CH_MASK_CLR_OFF = 5'h0C;
  localparam logic [4:0] CH_REQ_OFF = 5'h10;
  localparam logic [4:0] CH_LATCH_OFF = 5'h14;
  localparam logic [4:0] CH_PIN_OFF = 5'h18;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] ASSIGN_RST = 4'h0;
  localparam logic [5:0] CH_ZERO = 6'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] edge_mode;
    logic [31:0] both;
    logic [31:0] invert;
  } pin_cfg_t;

  // write-one-to-modify update shared by the direction, data, software request and channel mask words
  function automatic logic [31:0] w1m(input logic [31:0] cur, input logic [31:0] d,
                                      input logic wr_all, input logic set,
                                      input logic clr, input logic tgl);
    logic [31:0] r;
    r = cur;
    if (wr_all) begin
      r = d;
    end else if (set) begin
      r = cur | d;
    end else if (clr) begin
      r = cur & ~d;
    end else if (tgl) begin
      r = cur ^ d;
    end
    return r;
  endfunction

  // one assign bit enables eight consecutive pins
  function automatic logic [31:0] half_expand(input logic [3:0] a);
    logic [31:0] r;
    r = ZERO_WORD;
    for (int h = 0; h < NHALF; h++) begin
      r[h*HALF +: HALF] = {HALF{a[h]}};
    end
    return r;
  endfunction
endpackage

// ### logic/pin_irq_channel.sv
// one pin interrupt channel: half-port assignment, mask, latches, request output
// assumes pin levels and edge pulses already synchronised and polarity applied
`timescale 1ns/10ps
module pin_irq_channel #(
  parameter logic [7:0] BASE = 8'h40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire gpio_pkg::bus_req_t req,
  input wire logic [31:0] pin_raw,
  input wire logic [31:0] pin_level,
  input wire logic [31:0] pin_event,
  input wire logic [31:0] edge_mode,
  output logic [31:0] rd_word,
  output logic irq
);
  logic [3:0] assign_map;
  logic [31:0] mask;
  logic [31:0] latch;
  logic [3:0] next_assign_map;
  logic [31:0] next_mask;
  logic [31:0] next_latch;
  logic next_irq;
  logic hit;
  logic wr;
  logic [4:0] off;
  logic [31:0] en;
  logic [31:0] clr;

  always_comb begin
    hit = req.addr[7:gpio_pkg::CH_SHIFT] == BASE[7:gpio_pkg::CH_SHIFT];
    off = req.addr[4:0];
    wr = req.wr && hit;
    en = gpio_pkg::half_expand(assign_map);
    next_assign_map = (wr && off == gpio_pkg::CH_ASSIGN_OFF) ? req.wdata[3:0] : assign_map;
    next_mask = gpio_pkg::w1m(mask, req.wdata, wr && off == gpio_pkg::CH_MASK_OFF,
                              wr && off == gpio_pkg::CH_MASK_SET_OFF,
                              wr && off == gpio_pkg::CH_MASK_CLR_OFF, 1'b0);
    clr = (wr && (off == gpio_pkg::CH_REQ_OFF || off == gpio_pkg::CH_LATCH_OFF)) ?
          req.wdata : gpio_pkg::ZERO_WORD;
    // edge bits stick until cleared, new edge wins; level bits follow the pin
    next_latch = en & ((edge_mode & ((latch & ~clr) | pin_event)) |
                       (~edge_mode & pin_level));
    next_irq = |(latch & mask);
    rd_word = gpio_pkg::ZERO_WORD;
    if (hit) begin
      unique case (off)
        gpio_pkg::CH_ASSIGN_OFF: rd_word = {28'h000_0000, assign_map};
        gpio_pkg::CH_MASK_OFF: rd_word = mask;
        gpio_pkg::CH_REQ_OFF: rd_word = latch & mask;
        gpio_pkg::CH_LATCH_OFF: rd_word = latch;
        gpio_pkg::CH_PIN_OFF: rd_word = pin_raw & en;
        default: rd_word = gpio_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      assign_map <= gpio_pkg::ASSIGN_RST;
      mask <= gpio_pkg::ZERO_WORD;
      latch <= gpio_pkg::ZERO_WORD;
      irq <= 1'b0;
    end else begin
      assign_map <= next_assign_map;
      mask <= next_mask;
      latch <= next_latch;
      irq <= next_irq;
    end
  end
endmodule

// ### sim/gpio_port_checker.sv
// assertion checker for the gpio port top, bound to every instance
// assumes only the top ports; one clock, asynchronous active low reset
`timescale 1ns/10ps
module gpio_port_checker (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic [31:0] PIN_IN,
  input wire logic [31:0] PIN_OUT,
  input wire logic [31:0] PIN_OE,
  input wire logic [5:0] PIN_IRQ,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  property p_rd_idle;
    !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_dir_read;
    RD && ADDR == gpio_pkg::DIR_ADDR |=> RDATA == $past(PIN_OE);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read wrong");
  property p_data_wr;
    WR && ADDR == gpio_pkg::DATA_ADDR |=> PIN_OUT == $past(WDATA);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write wrong");
  property p_data_set;
    WR && ADDR == gpio_pkg::DATA_SET_ADDR |=> PIN_OUT == ($past(PIN_OUT) | $past(WDATA));
  endproperty
  a_data_set: assert property (p_data_set) else $error("data set wrong");
  property p_data_clr;
    WR && ADDR == gpio_pkg::DATA_CLR_ADDR |=> PIN_OUT == ($past(PIN_OUT) & ~$past(WDATA));
  endproperty
  a_data_clr: assert property (p_data_clr) else $error("data clear wrong");
  property p_data_tgl;
    WR && ADDR == gpio_pkg::DATA_TGL_ADDR |=> PIN_OUT == ($past(PIN_OUT) ^ $past(WDATA));
  endproperty
  a_data_tgl: assert property (p_data_tgl) else $error("data toggle wrong");
  property p_dir_clr;
    WR && ADDR == gpio_pkg::DIR_CLR_ADDR |=> PIN_OE == ($past(PIN_OE) & ~$past(WDATA));
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("direction clear wrong");
  property p_port_hold;
    !WR || ADDR >= 8'h1C |=> $stable(PIN_OUT) && $stable(PIN_OE);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port changed");
endmodule

bind gpio_port gpio_port_checker u_gpio_port_checker (.MCLK(MCLK), .RESETN(RESETN),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_IRQ(PIN_IRQ), .IRQ(IRQ));

// ### sim/gpio_port_with_pin_interrupts_tb_top.sv
// self-checking bench for the gpio port with pin interrupts
// assumes the design and checker compiled first; bench drives every port
`timescale 1ns/10ps
module gpio_port_with_pin_interrupts_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] pin_in = 32'h0000_0000;
  logic [31:0] rdata, pin_out, pin_oe, d, m, r;
  logic [5:0] pin_irq;
  logic irq;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int n_checks = 0;

  always #50 mclk = ~mclk;

  gpio_port u_gpio_port (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_IRQ(pin_irq), .IRQ(irq));

  function automatic logic [7:0] ch(input int c, input logic [4:0] o);
    return 8'(64 + 32 * c + int'(o));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // read data show one cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic tick(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one edge on pin 0, or on its software request when it is an output
  task automatic edge_case(input logic both, inv, out, a, b, e);
    wr_reg(gpio_pkg::SENSE_ADDR, 32'h0000_0001);
    wr_reg(gpio_pkg::BOTH_ADDR, {31'h0, both});
    wr_reg(gpio_pkg::INVERT_ADDR, {31'h0, inv});
    wr_reg(gpio_pkg::DIR_ADDR, {31'h0, out});
    wr_reg(gpio_pkg::SWREQ_ADDR, {31'h0, a & out});
    pin_in <= {31'h0, a & ~out};
    tick(8);
    wr_reg(ch(0, gpio_pkg::CH_LATCH_OFF), '1);
    wr_reg(gpio_pkg::SWREQ_ADDR, {31'h0, b & out});
    pin_in <= {31'h0, b & ~out};
    tick(10);
    rd_reg(ch(0, gpio_pkg::CH_LATCH_OFF), {31'h0, e});
    chk(pin_irq, {5'h0, e});
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    $display("Error at %0t: timeout", $time);
    give_verdict();
  end

  initial begin
    void'($urandom(32'h52ff));
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd_reg(gpio_pkg::DIR_ADDR, 0);
    rd_reg(gpio_pkg::DATA_ADDR, 0);
    rd_reg(ch(5, gpio_pkg::CH_ASSIGN_OFF), 0);
    wr_reg(8'hFC, '1);
    rd_reg(8'hFC, 0);
    $display("reset values done");
    d = $urandom();
    m = $urandom();
    r = $urandom();
    wr_reg(gpio_pkg::DATA_ADDR, d);
    wr_reg(gpio_pkg::DATA_SET_ADDR, m);
    wr_reg(gpio_pkg::DATA_CLR_ADDR, r);
    wr_reg(gpio_pkg::DATA_TGL_ADDR, m ^ r);
    d = ((d | m) & ~r) ^ (m ^ r);
    rd_reg(gpio_pkg::DATA_ADDR, d);
    wr_reg(gpio_pkg::DIR_ADDR, m);
    wr_reg(gpio_pkg::DIR_SET_ADDR, r);
    wr_reg(gpio_pkg::DIR_CLR_ADDR, d);
    m = (m | r) & ~d;
    rd_reg(gpio_pkg::DIR_ADDR, m);
    tick(1);
    chk(pin_oe, m);
    chk(pin_out, d);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'(32 + 4 * i), $urandom());
    end
    wr_reg(ch(1, gpio_pkg::CH_MASK_OFF), $urandom());
    rd_reg(gpio_pkg::DATA_ADDR, d);
    rd_reg(gpio_pkg::DIR_ADDR, m);
    r = $urandom();
    pin_in <= r;
    tick(6);
    rd_reg(gpio_pkg::PIN_ADDR, r);
    $display("port registers done");
    wr_reg(gpio_pkg::DIR_ADDR, 0);
    wr_reg(gpio_pkg::SWREQ_ADDR, 0);
    wr_reg(gpio_pkg::SENSE_ADDR, 0);
    wr_reg(gpio_pkg::INVERT_ADDR, 0);
    wr_reg(gpio_pkg::IRQ_MASK_ADDR, '1);
    for (int c = 0; c < 6; c++) begin
      wr_reg(ch(c, gpio_pkg::CH_ASSIGN_OFF), 32'(1 << (c % 4)));
      wr_reg(ch(c, gpio_pkg::CH_MASK_SET_OFF), '1);
    end
    for (int h = 0; h < 4; h++) begin
      pin_in <= 32'(1) << (8 * h + $urandom_range(7));
      tick(10);
      chk(pin_irq, (h < 2) ? (6'h11 << h) : (6'h01 << h));
    end
    pin_in <= 32'h0000_0001;
    wr_reg(ch(4, gpio_pkg::CH_MASK_CLR_OFF), '1);
    tick(10);
    chk(pin_irq, 6'h01);
    chk(irq, 1'b1);
    rd_reg(ch(4, gpio_pkg::CH_LATCH_OFF), 32'h0000_0001);
    rd_reg(ch(4, gpio_pkg::CH_REQ_OFF), 0);
    pin_in <= 32'h0000_0000;
    tick(10);
    wr_reg(gpio_pkg::IRQ_STAT_ADDR, '1);
    tick(3);
    chk(irq, 1'b0);
    $display("routing and level done");
    edge_case(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    edge_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    edge_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    edge_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    edge_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    tick(2);
    $display("edge modes done");
    give_verdict();
  end
endmodule
